/* core/dmap_pkg.sv */
// constants shared by the debug memory access port data path
package dmap_pkg;

	// ----------------------------------------------------------------
	// register byte offsets on the wishbone slave
	// ----------------------------------------------------------------
	localparam logic [7:0] DMAP_OFS_TAR = 8'h00;
	localparam logic [7:0] DMAP_OFS_CSW = 8'h04;
	localparam logic [7:0] DMAP_OFS_STATUS = 8'h08;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DMAP_ACCESS_SIZE_FIELD_LSB = 0;
	localparam int DMAP_ACCESS_SIZE_FIELD_W = 3;
	localparam int DMAP_STATUS_BUSY_BIT = 0;
	localparam int DMAP_STATUS_STICKY_BIT = 1;

	// ----------------------------------------------------------------
	// access size encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] DMAP_SIZE_BYTE = 3'h0;
	localparam logic [2:0] DMAP_SIZE_HALF = 3'h1;
	localparam logic [2:0] DMAP_SIZE_WORD = 3'h2;
	localparam logic [2:0] DMAP_SIZE_DWORD = 3'h3;
	localparam logic [2:0] DMAP_SIZE_128 = 3'h4;
	localparam logic [2:0] DMAP_SIZE_256 = 3'h5;

	// ----------------------------------------------------------------
	// unaligned handling choices
	// ----------------------------------------------------------------
	localparam logic [1:0] DMAP_UNAL_IGNORE = 2'h0;
	localparam logic [1:0] DMAP_UNAL_FAULT = 2'h1;
	localparam logic [1:0] DMAP_UNAL_EXACT = 2'h2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] DMAP_TAR_RST = 32'h0000_0000;
	localparam logic [2:0] DMAP_SIZE_RST = 3'h2;
	localparam logic [31:0] DMAP_DATA_RST = 32'h0000_0000;

endpackage : dmap_pkg

/* core/dmap_lane_steer.sv */
// byte-lane enables from access size and low address bits
module dmap_lane_steer
	import dmap_pkg::*;
(
	// access description
	input wire logic [2:0] size_i,
	input wire logic [1:0] addr_lo_i,
	// lane selection
	output logic [3:0] be_o
);
	import dmap_pkg::*;

	// lowest address maps to the least significant lane
	always_comb begin
		be_o = 4'hF;
		case (size_i)
			DMAP_SIZE_BYTE: begin
				be_o = 4'h1 << addr_lo_i;
			end
			DMAP_SIZE_HALF: begin
				be_o = addr_lo_i[1] ? 4'hC : 4'h3;
			end
			default: begin
				be_o = 4'hF;
			end
		endcase
	end

endmodule : dmap_lane_steer

/* core/dmap_wb_regs.sv */
// wishbone slave holding address, control and status registers
module dmap_wb_regs
	import dmap_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter bit SUPPORT_SUBWORD = 1'b1
) (
	// clocking
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// block state
	input wire logic busy_i,
	input wire logic err_set_i,
	output logic [31:0] tar_o,
	output logic [2:0] size_o,
	output logic sticky_o
);
	import dmap_pkg::*;

	logic acc;
	logic [7:0] ofs;
	logic [31:0] rd_next;

	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign ofs = wb_adr_i[7:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= acc;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tar_o <= DMAP_TAR_RST;
		end else if (ce_i && acc && wb_we_i && ofs == DMAP_OFS_TAR) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					tar_o[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				end
			end
		end
	end

	// reserved and large sizes are refused: the old size stays
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			size_o <= DMAP_SIZE_RST;
		end else if (ce_i && SUPPORT_SUBWORD && acc && wb_we_i && wb_sel_i[0]
				&& ofs == DMAP_OFS_CSW
				&& wb_dat_i[DMAP_ACCESS_SIZE_FIELD_LSB +: DMAP_ACCESS_SIZE_FIELD_W] <= DMAP_SIZE_WORD) begin
			size_o <= wb_dat_i[DMAP_ACCESS_SIZE_FIELD_LSB +: DMAP_ACCESS_SIZE_FIELD_W];
		end
	end

	// set wins over a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sticky_o <= 1'b0;
		end else if (ce_i) begin
			if (err_set_i) begin
				sticky_o <= 1'b1;
			end else if (acc && wb_we_i && wb_sel_i[0] && ofs == DMAP_OFS_STATUS
					&& wb_dat_i[DMAP_STATUS_STICKY_BIT]) begin
				sticky_o <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_next = 32'h0000_0000;
		case (ofs)
			DMAP_OFS_TAR: rd_next = tar_o;
			DMAP_OFS_CSW: rd_next[DMAP_ACCESS_SIZE_FIELD_LSB +: DMAP_ACCESS_SIZE_FIELD_W] = size_o;
			DMAP_OFS_STATUS: begin
				rd_next[DMAP_STATUS_BUSY_BIT] = busy_i;
				rd_next[DMAP_STATUS_STICKY_BIT] = sticky_o;
			end
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			wb_dat_o <= acc ? rd_next : 32'h0000_0000;
		end
	end

endmodule : dmap_wb_regs

/* core/dmap_datapath.sv */
// memory access port data path: debug port front, stalling and sized memory accesses
//
// Overview of operation
// - data and banked data accesses may stall without bound until memory completes.
// - answer OK/FAULT whenever ready, only after target completed earlier transfer.
// - answer WAIT while the access port is still busy.
// - not ready at capture: discard request at update, forward nothing.
// - ready at capture: start requested transfer at update.
// - stay busy while target holds off; ready only after completion.
// - downstream error is reported and sets the sticky error flag.
// - without large data, support byte, halfword and word together.
// - size codes: byte 000, half 001, word 010, 64/128/256 011-101.
// - word-only build: size field read-only, always word.
// - sizes 64, 128 and 256 bits are reserved here.
// - sub-word lanes chosen by size and two low address bits.
// - byte lanes 7:0, 15:8, 23:16, 31:24 for addresses 00..11.
// - halfword lanes 15:0 at 00, 31:16 at 10; word uses all.
// - unaligned: ignore low bits, fault, or access exact address.
// - exact unaligned access is packed and split into byte accesses.
// - packed byte and halfword beats use the same lanes.
// - transfer address register supplies the memory address.
module dmap_datapath
	import dmap_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter bit SUPPORT_SUBWORD = 1'b1,
	parameter logic [1:0] UNALIGN_MODE = DMAP_UNAL_EXACT
) (
	// clocking
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// debug port front
	input wire logic capture_dr_i,
	input wire logic update_dr_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_banked_i,
	input wire logic [1:0] req_bank_i,
	input wire logic [31:0] req_wdata_i,
	output logic ack_wait_o,
	output logic [31:0] rd_data_o,
	output logic sticky_error_o,
	// downstream memory port
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [2:0] mem_size_o,
	output logic [3:0] mem_be_o,
	output logic [31:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic mem_err_i,
	input wire logic [31:0] mem_rdata_i
);
	import dmap_pkg::*;

	typedef enum logic {
		S_IDLE,
		S_ACCESS
	} dmap_state_t;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dmap_state_t state_reg;
	logic ready_cap_reg;
	logic [1:0] beats_left_reg;
	logic [31:0] data_read_write_reg;
	logic err_set_reg;
	logic [31:0] transfer_address_reg;
	logic [2:0] access_size_field;

	// ----------------------------------------------------------------
	// request decode
	// ----------------------------------------------------------------
	logic start;
	logic beat_done;
	logic last_beat;
	logic [31:0] base_addr;
	logic [2:0] req_size;
	logic misaligned;
	logic split;
	logic fault;
	logic [31:0] start_addr;
	logic [2:0] start_size;
	logic [1:0] start_beats;
	logic [31:0] next_addr;
	logic [2:0] next_size;
	logic [3:0] next_be;
	logic [31:0] merged;

	// ----------------------------------------------------------------
	// size and address selection
	// ----------------------------------------------------------------
	assign req_size = SUPPORT_SUBWORD ? access_size_field : DMAP_SIZE_WORD;

	// banked registers sit at the four words of the aligned 16-byte block
	assign base_addr = req_banked_i
		? {transfer_address_reg[31:4], req_bank_i, 2'b00}
		: transfer_address_reg;

	assign misaligned = (req_size == DMAP_SIZE_HALF && base_addr[0])
		|| (req_size == DMAP_SIZE_WORD && base_addr[1:0] != 2'b00);

	assign split = misaligned && UNALIGN_MODE == DMAP_UNAL_EXACT;
	assign fault = misaligned && UNALIGN_MODE == DMAP_UNAL_FAULT;

	// discard unless the port was ready when the answer was captured
	assign start = update_dr_i && req_valid_i && ready_cap_reg && state_reg == S_IDLE;

	// ----------------------------------------------------------------
	// unaligned handling, fixed at build time
	// ----------------------------------------------------------------
	always_comb begin
		start_addr = base_addr;
		start_size = req_size;
		start_beats = 2'd0;
		if (misaligned && UNALIGN_MODE == DMAP_UNAL_IGNORE) begin
			start_addr = (req_size == DMAP_SIZE_HALF)
				? {base_addr[31:1], 1'b0}
				: {base_addr[31:2], 2'b00};
		end else if (split) begin
			// byte beats keep the lane mapping simple at any start address
			start_size = DMAP_SIZE_BYTE;
			start_beats = (req_size == DMAP_SIZE_HALF) ? 2'd1 : 2'd3;
		end
	end

	assign beat_done = state_reg == S_ACCESS && mem_ack_i;
	assign last_beat = beats_left_reg == 2'd0;

	always_comb begin
		next_addr = mem_addr_o;
		next_size = mem_size_o;
		if (state_reg == S_IDLE) begin
			next_addr = start_addr;
			next_size = start_size;
		end else begin
			next_addr = mem_addr_o + 32'h0000_0001;
			next_size = DMAP_SIZE_BYTE;
		end
	end

	dmap_lane_steer u_steer (
		.size_i(next_size),
		.addr_lo_i(next_addr[1:0]),
		.be_o(next_be)
	);

	// ----------------------------------------------------------------
	// read data packing into the data register
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_lane
		assign merged[g*8 +: 8] = mem_be_o[g]
			? mem_rdata_i[g*8 +: 8]
			: data_read_write_reg[g*8 +: 8];
	end

	// ----------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= S_IDLE;
		end else if (ce_i) begin
			case (state_reg)
				S_IDLE: begin
					if (start && !fault) begin
						state_reg <= S_ACCESS;
					end
				end
				S_ACCESS: begin
					// no timeout: the target may hold off for ever
					if (beat_done && (mem_err_i || last_beat)) begin
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// memory request
	// ----------------------------------------------------------------
	// one beat outstanding; request stays up between split beats
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_req_o <= 1'b0;
		end else if (ce_i) begin
			if (state_reg == S_IDLE) begin
				mem_req_o <= start && !fault;
			end else if (beat_done) begin
				mem_req_o <= !mem_err_i && !last_beat;
			end
		end
	end

	// address, size, lanes and data only move on start or on an accepted beat
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mem_addr_o <= DMAP_TAR_RST;
			mem_size_o <= DMAP_SIZE_RST;
			mem_be_o <= 4'h0;
			mem_we_o <= 1'b0;
			beats_left_reg <= 2'd0;
		end else if (ce_i) begin
			if ((state_reg == S_IDLE && start && !fault)
					|| (beat_done && !mem_err_i && !last_beat)) begin
				mem_addr_o <= next_addr;
				mem_size_o <= next_size;
				mem_be_o <= next_be;
				beats_left_reg <= (state_reg == S_IDLE)
					? start_beats
					: beats_left_reg - 2'd1;
			end
			if (state_reg == S_IDLE && start) begin
				mem_we_o <= req_write_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// data register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_read_write_reg <= DMAP_DATA_RST;
		end else if (ce_i) begin
			if (state_reg == S_IDLE && start && req_write_i) begin
				data_read_write_reg <= req_wdata_i;
			end else if (beat_done && !mem_err_i && !mem_we_o) begin
				data_read_write_reg <= merged;
			end
		end
	end

	assign mem_wdata_o = data_read_write_reg;

	// ----------------------------------------------------------------
	// error report to the sticky flag
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_set_reg <= 1'b0;
		end else if (ce_i) begin
			err_set_reg <= (beat_done && mem_err_i)
				|| (state_reg == S_IDLE && start && fault);
		end
	end

	// ----------------------------------------------------------------
	// debug port front answer
	// ----------------------------------------------------------------
	// busy is taken from the sequencer, not from the target's acceptance
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_cap_reg <= 1'b0;
			ack_wait_o <= 1'b0;
			rd_data_o <= DMAP_DATA_RST;
		end else if (ce_i && capture_dr_i) begin
			ready_cap_reg <= state_reg == S_IDLE;
			ack_wait_o <= state_reg != S_IDLE;
			rd_data_o <= data_read_write_reg;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	dmap_wb_regs #(
		.ADDR_W(ADDR_W),
		.SUPPORT_SUBWORD(SUPPORT_SUBWORD)
	) u_regs (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.busy_i(state_reg != S_IDLE),
		.err_set_i(err_set_reg),
		.tar_o(transfer_address_reg),
		.size_o(access_size_field),
		.sticky_o(sticky_error_o)
	);

endmodule : dmap_datapath

/* sim/dmap_mem_model.sv */
// memory target model for the downstream port of the data path
module dmap_mem_model (
	// clocking
	input wire logic clk_i,
	// request from the data path
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [31:0] addr_i,
	input wire logic [3:0] be_i,
	input wire logic [31:0] wdata_i,
	// behaviour set by the bench
	input wire logic [3:0] dly_i,
	input wire logic err_i,
	// answer
	output logic ack_o,
	output logic err_o,
	output logic [31:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [256];
	logic [3:0] cnt = 4'h0;
	logic [7:0] base;
	initial begin
		ack_o = 1'b0;
		err_o = 1'b0;
		rdata_o = 32'h0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	assign base = {addr_i[7:2], 2'b00};
	// ----
	// answer after a delay; read data is only valid with ack
	// ----
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		err_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o) begin
			if (cnt == dly_i) begin
				cnt <= 4'h0;
				ack_o <= 1'b1;
				err_o <= err_i;
				rdata_o <= {mem[base+8'h3], mem[base+8'h2], mem[base+8'h1], mem[base]};
				for (int k = 0; k < 4; k++) begin
					if (we_i && be_i[k]) mem[base+8'(k)] <= wdata_i[8*k+:8];
				end
			end else cnt <= cnt + 4'h1;
		end else cnt <= 4'h0;
	end
endmodule : dmap_mem_model

/* sim/dmap_datapath_assertions.sv */
// concurrent checks on the memory access port data path
module dmap_datapath_chk
	import dmap_pkg::*;
(
	// clocking
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// debug front
	input wire logic capture_dr_i,
	input wire logic update_dr_i,
	input wire logic req_valid_i,
	input wire logic ack_wait_o,
	input wire logic sticky_error_o,
	// memory port
	input wire logic mem_req_o,
	input wire logic mem_we_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [2:0] mem_size_o,
	input wire logic [3:0] mem_be_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic mem_err_i
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic cap_seen_reg;
	// a capture since the last update makes the ready answer meaningful
	always_ff @(posedge clk_i) begin
		if (rst_i || update_dr_i) cap_seen_reg <= 1'b0;
		else if (capture_dr_i) cap_seen_reg <= 1'b1;
	end
	// ----
	// assertions
	// ----
	chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
		&& $stable(mem_addr_o) && $stable(mem_be_o) && $stable(mem_wdata_o) && $stable(mem_we_o))
		else $error("memory request changed while stalled");
	chk_wb_answer: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus cycle not acknowledged");
	chk_byte_lane: assert property (mem_req_o && mem_size_o == DMAP_SIZE_BYTE |->
		mem_be_o == (4'h1 << mem_addr_o[1:0])) else $error("byte lane wrong");
	chk_half_lane: assert property (mem_req_o && mem_size_o == DMAP_SIZE_HALF |->
		mem_be_o == (mem_addr_o[1] ? 4'hC : 4'h3) && !mem_addr_o[0]) else $error("half lanes wrong");
	chk_word_lane: assert property (mem_req_o && mem_size_o == DMAP_SIZE_WORD |->
		mem_be_o == 4'hF && mem_addr_o[1:0] == 2'h0) else $error("word lanes wrong");
	chk_size_legal: assert property (mem_req_o |-> mem_size_o <= DMAP_SIZE_WORD)
		else $error("reserved size on memory port");
	chk_err_sticky: assert property (mem_req_o && mem_ack_i && mem_err_i |-> ##2 sticky_error_o)
		else $error("error did not set sticky flag");
	chk_wait_busy: assert property ($rose(ack_wait_o) |-> $past(capture_dr_i) && $past(mem_req_o))
		else $error("wait answered while idle");
	chk_ok_idle: assert property (ce_i && capture_dr_i && !mem_req_o |=> !ack_wait_o)
		else $error("wait answered while ready");
	chk_start_req: assert property (ce_i && update_dr_i && req_valid_i && cap_seen_reg
		&& !ack_wait_o
		&& !mem_req_o |=> mem_req_o) else $error("transfer not started at update");
	cover property (mem_req_o && mem_ack_i && mem_err_i);
	cover property (capture_dr_i ##1 ack_wait_o);
	cover property (mem_req_o && mem_size_o == DMAP_SIZE_BYTE && mem_addr_o[1:0] == 2'h3);
endmodule : dmap_datapath_chk

bind dmap_datapath dmap_datapath_chk u_chk (
	.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .capture_dr_i, .update_dr_i,
	.req_valid_i, .ack_wait_o, .sticky_error_o, .mem_req_o, .mem_we_o, .mem_addr_o,
	.mem_size_o, .mem_be_o, .mem_wdata_o, .mem_ack_i, .mem_err_i
);

/* sim/tb.sv */
// self-checking bench for the memory access port data path
module tb;
	import dmap_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic we; logic [2:0] sz; logic [3:0] be; logic [31:0] a, d;} dmap_beat_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic cap = 1'b0;
	logic upd = 1'b0;
	logic rv = 1'b0;
	logic rw = 1'b0;
	logic rb = 1'b0;
	logic [1:0] rbk = 2'h0;
	logic [31:0] rwd = 32'h0;
	logic [3:0] dly = 4'h0;
	logic err = 1'b0;
	logic [31:0] wdo, rdd, maddr, mwd, mrd, a, d, rd;
	logic ack, ack_wait, stk, mreq, mwe, mack, merr;
	logic [2:0] msz;
	logic [3:0] mbe, m;
	dmap_beat_t q[$];
	dmap_beat_t e;
	int n_mismatch = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 32'h163f7a0f;
	dmap_datapath DUT (
		.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wdo), .wb_ack_o(ack),
		.capture_dr_i(cap), .update_dr_i(upd), .req_valid_i(rv), .req_write_i(rw),
		.req_banked_i(rb), .req_bank_i(rbk), .req_wdata_i(rwd), .ack_wait_o(ack_wait),
		.rd_data_o(rdd), .sticky_error_o(stk), .mem_req_o(mreq), .mem_we_o(mwe),
		.mem_addr_o(maddr), .mem_size_o(msz), .mem_be_o(mbe), .mem_wdata_o(mwd),
		.mem_ack_i(mack), .mem_err_i(merr), .mem_rdata_i(mrd)
	);
	dmap_mem_model mem_model (
		.clk_i(clk), .req_i(mreq), .we_i(mwe), .addr_i(maddr), .be_i(mbe), .wdata_i(mwd),
		.dly_i(dly), .err_i(err), .ack_o(mack), .err_o(merr), .rdata_o(mrd)
	);
	initial forever #25 clk = ~clk;
	// ----
	// helpers
	// ----
	function automatic logic [31:0] lm(input logic [3:0] be);
		for (int k = 0; k < 4; k++) lm[8*k+:8] = {8{be[k]}};
	endfunction : lm
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic wbx(input logic w, input logic [7:0] ad, input logic [31:0] dd, output logic [31:0] r);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= ad;
		dat <= dd;
		do @(posedge clk); while (ack !== 1'b1);
		r = wdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wbx
	task automatic capt();
		@(posedge clk);
		cap <= 1'b1;
		@(posedge clk);
		cap <= 1'b0;
		@(posedge clk);
	endtask : capt
	task automatic acc(input logic w, input logic b, input logic [1:0] n, input logic [31:0] dd, bit wt);
		capt();
		upd <= 1'b1;
		rv <= 1'b1;
		rw <= w;
		rb <= b;
		rbk <= n;
		rwd <= dd;
		@(posedge clk);
		upd <= 1'b0;
		rv <= 1'b0;
		if (wt) do @(posedge clk); while (mreq === 1'b1);
	endtask : acc
	// expected beats; unaligned sizes split into byte beats in address order
	task automatic push(input logic w, input logic [31:0] ad, input logic [2:0] s, input logic [31:0] dd);
		dmap_beat_t b;
		int n;
		n = (s == 3'h1 && ad[0]) ? 2 : (s == 3'h2 && ad[1:0] != 2'h0) ? 4 : 1;
		m = 4'h0;
		for (int k = 0; k < n; k++) begin
			b.a = ad + 32'(k);
			b.sz = (n > 1) ? 3'h0 : s;
			b.be = (n > 1 || s == 3'h0) ? 4'h1 << b.a[1:0] : (s == 3'h1) ? 4'h3 << ad[1:0] : 4'hF;
			b.we = w;
			b.d = dd & lm(b.be);
			m = m | b.be;
			q.push_back(b);
		end
	endtask : push
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// ----
	// monitor and timeout
	// ----
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_mismatch++;
			results();
		end else if (mreq === 1'b1 && mack === 1'b1) begin
			if (q.size() == 0) chk("extra beat", 32'h0, 32'h1);
			else begin
				e = q.pop_front();
				chk("beat addr", e.a, maddr);
				chk("beat kind", 32'({e.we, e.sz, e.be}), 32'({mwe, msz, mbe}));
				if (e.we) chk("beat data", e.d, mwd & lm(e.be));
			end
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wbx(0, DMAP_OFS_TAR, 32'h0, rd);
		chk("address reset", DMAP_TAR_RST, rd);
		for (int s = 0; s < 8; s++) begin
			wbx(1, DMAP_OFS_CSW, 32'(s), rd);
			wbx(0, DMAP_OFS_CSW, 32'h0, rd);
			chk("size field", (s < 3) ? 32'(s) : 32'(DMAP_SIZE_RST), rd & 32'h7);
		end
		wbx(1, 8'h0C, 32'hFFFF_FFFF, rd);
		wbx(0, 8'h0C, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		for (int s = 0; s < 3; s++) for (int lo = 0; lo < 4; lo++) begin
			a = $random(seed);
			a[1:0] = 2'(lo);
			d = $random(seed);
			dly <= 4'($random(seed)) & 4'h3;
			wbx(1, DMAP_OFS_TAR, a, rd);
			wbx(1, DMAP_OFS_CSW, 32'(s), rd);
			push(1, a, 3'(s), d);
			acc(1, 1'b0, 2'h0, d, 1);
			wbx(1, DMAP_OFS_TAR, a ^ 32'h80, rd);
			push(1, a ^ 32'h80, 3'(s), ~d);
			acc(1, 1'b0, 2'h0, ~d, 1);
			wbx(1, DMAP_OFS_TAR, a, rd);
			push(0, a, 3'(s), 32'h0);
			acc(0, 1'b0, 2'h0, ~d, 1);
			capt();
			chk("read data", d & lm(m), rdd & lm(m));
			chk("ready answer", 32'h0, 32'(ack_wait));
		end
		wbx(1, DMAP_OFS_CSW, 32'h2, rd);
		push(1, {a[31:4], 4'h8}, 3'h2, d);
		acc(1, 1'b1, 2'h2, d, 1);
		dly <= 4'hC;
		push(1, a, 3'h2, d);
		acc(1, 1'b0, 2'h0, d, 0);
		acc(1, 1'b0, 2'h0, ~d, 0);
		chk("wait answer", 32'h1, 32'(ack_wait));
		while (mreq === 1'b1) @(posedge clk);
		capt();
		chk("ready again", 32'h0, 32'(ack_wait));
		push(1, a, 3'h2, ~d);
		acc(1, 1'b0, 2'h0, ~d, 1);
		dly <= 4'h1;
		err <= 1'b1;
		push(1, a, 3'h2, d);
		repeat (3) void'(q.pop_back());
		acc(1, 1'b0, 2'h0, d, 1);
		err <= 1'b0;
		capt();
		chk("sticky", 32'h1, 32'(stk));
		wbx(0, DMAP_OFS_STATUS, 32'h0, rd);
		chk("status", 32'h2, rd & 32'h3);
		wbx(1, DMAP_OFS_STATUS, 32'h2, rd);
		chk("sticky clear", 32'h0, 32'(stk));
		chk("beats left", 32'h0, 32'(q.size()));
		results();
	end
endmodule : tb
